//--- src/bldc_brake_device.sv
// motor driver end: mode select, ramped duty, protections
//
// Behaviour
// - brake_select low brakes, high or float runs
// - commands act the same in generator mode
// - braking disables overcurrent and current limiting
// - disable stops bridge, duty value kept
// - commands take effect after 64us conversion
// - host disables and zeroes commands before braking
// - host waits 128us plus delay first
// - command below threshold counts as zero
// - host re-enables, then ramp rate first
// - host waits conversion before changing duty
// - ramp code 105 gives about 60s sweep
// - duty code 205 targets about 80 percent
// - braking needs the unlock jumper shorted
// - heat sink above 85C locks out
// - over 405V faults, restarts below 395V
// - braking inactive as delivered
`timescale 1ns/10ps
`include "brake_params.svh"
module bldc_brake_device
	import brake_pkg::*;
(
	input wire logic clk_sys, // 25 MHz clock
	input wire logic reset, // synchronous, active high
	brake_if.device link, // host pins
	input wire logic brakeUnlockJumper, // high when jumper shorted
	input wire logic [9:0] busVolts, // rectified bus voltage
	input wire logic [7:0] sinkTempC, // heat sink temperature
	input wire logic overCurrent, // bridge over-current detect
	input wire logic avgCurrentHigh, // average current over limit
	output logic bridgeOn_q, // bridge driven, else tri-state
	output logic generatorMode_q, // braking mode active
	output logic [7:0] pwmDuty_q, // applied duty
	output logic faultOutN_q // fault, active low
);
	logic [2:0] brkSync_q;
	logic [2:0] enSync_q;
	logic [2:0] jmpSync_q;
	logic [2:0] ocSync_q;
	logic [2:0] avgSync_q;
	logic brkN_q;
	logic en_q;
	logic jmp_q;
	logic oc_q;
	logic avgHigh_q;
	logic [15:0] adcCnt_q;
	logic [7:0] dutyTarget_q;
	logic [7:0] rampCode_q;
	logic [31:0] stepCnt_q;
	logic [31:0] stepLen_d;
	logic overVolt_q;
	logic overTemp_q;
	logic protect;

	// a pin change counts once the second and third stages agree
	function automatic logic agreeNext(input logic [2:0] chain,
			input logic held);
		agreeNext = (chain[1] == chain[2]) ? chain[2] : held;
	endfunction

	function automatic logic [7:0] zeroBelow(input logic [7:0] code);
		zeroBelow = (code < `CMD_ZERO_CODE) ? `DUTY_ZERO : code;
	endfunction

	// brake pin idles high; a low chain after reset would fake a brake
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			brkSync_q <= 3'h7;
			brkN_q <= 1'b1;
		end else begin
			brkSync_q <= {brkSync_q[1:0], link.brakeSelectN};
			brkN_q <= agreeNext(brkSync_q, brkN_q);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			enSync_q <= 3'h0;
			en_q <= 1'b0;
		end else begin
			enSync_q <= {enSync_q[1:0], link.driveEnable};
			en_q <= agreeNext(enSync_q, en_q);
		end
	end

	// jumper is a board strap, filtered like any other pin
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			jmpSync_q <= 3'h0;
			jmp_q <= 1'b0;
		end else begin
			jmpSync_q <= {jmpSync_q[1:0], brakeUnlockJumper};
			jmp_q <= agreeNext(jmpSync_q, jmp_q);
		end
	end

	// current detectors are free-running comparators, not clocked logic
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ocSync_q <= 3'h0;
			oc_q <= 1'b0;
		end else begin
			ocSync_q <= {ocSync_q[1:0], overCurrent};
			oc_q <= agreeNext(ocSync_q, oc_q);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			avgSync_q <= 3'h0;
			avgHigh_q <= 1'b0;
		end else begin
			avgSync_q <= {avgSync_q[1:0], avgCurrentHigh};
			avgHigh_q <= agreeNext(avgSync_q, avgHigh_q);
		end
	end

	// jumper gates the brake pin; without it stays motor mode
	always_ff @(posedge clk_sys) begin
		if (reset)
			generatorMode_q <= 1'b0;
		else
			generatorMode_q <= !brkN_q && jmp_q;
	end

	// commands sampled once per conversion period
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			adcCnt_q <= 16'h0000;
			dutyTarget_q <= `DUTY_ZERO;
			rampCode_q <= `DUTY_ZERO;
		end else if (adcCnt_q == 16'(`ADC_CYCLES - 1)) begin
			adcCnt_q <= 16'h0000;
			dutyTarget_q <= zeroBelow(link.dutyCommand);
			rampCode_q <= zeroBelow(link.rampRateCommand);
		end else begin
			adcCnt_q <= adcCnt_q + 16'h0001;
		end
	end

	// step length scales with ramp code; zero code steps every cycle
	always_comb begin
		stepLen_d = 32'h00000001;
		if (rampCode_q != `DUTY_ZERO)
			stepLen_d = 32'((64'(`RAMP_STEP_CYCLES) * 64'(rampCode_q))
				/ 64'(`RAMP_REF_CODE));
	end

	// braking turns both current protections off
	always_comb begin
		protect = !generatorMode_q && (oc_q || avgHigh_q);
	end

	// duty ramps toward target in both modes, stepping down on average-current high in motor mode only with a nonzero ramp code; kept while disabled
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pwmDuty_q <= `DUTY_ZERO;
			stepCnt_q <= 32'h00000000;
		end else if (stepCnt_q + 32'h00000001 >= stepLen_d) begin
			stepCnt_q <= 32'h00000000;
			if (!generatorMode_q && avgHigh_q && rampCode_q != 8'h00
					&& pwmDuty_q != `DUTY_ZERO)
				pwmDuty_q <= pwmDuty_q - 8'h01;
			else if (pwmDuty_q < dutyTarget_q)
				pwmDuty_q <= pwmDuty_q + 8'h01;
			else if (pwmDuty_q > dutyTarget_q)
				pwmDuty_q <= pwmDuty_q - 8'h01;
		end else begin
			stepCnt_q <= stepCnt_q + 32'h00000001;
		end
	end

	// over-voltage lockout; the gap between trip and clear stops chatter
	always_ff @(posedge clk_sys) begin
		if (reset)
			overVolt_q <= 1'b0;
		else if (busVolts > `OV_TRIP_V)
			overVolt_q <= 1'b1;
		else if (busVolts < `OV_CLEAR_V)
			overVolt_q <= 1'b0;
	end

	// heat-sink lockout, restarts on its own once cooled
	always_ff @(posedge clk_sys) begin
		if (reset)
			overTemp_q <= 1'b0;
		else if (sinkTempC > `OT_TRIP_C)
			overTemp_q <= 1'b1;
		else if (sinkTempC < `OT_CLEAR_C)
			overTemp_q <= 1'b0;
	end

	// over-current pulls the fault pin only in motor mode
	always_ff @(posedge clk_sys) begin
		if (reset)
			faultOutN_q <= 1'b1;
		else
			faultOutN_q <= !(overVolt_q || overTemp_q
				|| (oc_q && !generatorMode_q));
	end

	// disable stops the bridge only; the duty register is left alone
	always_ff @(posedge clk_sys) begin
		if (reset)
			bridgeOn_q <= 1'b0;
		else
			bridgeOn_q <= en_q && !overVolt_q && !overTemp_q
				&& !protect;
	end

	assign link.faultOutN = faultOutN_q;
endmodule

//--- src/bldc_brake_host.sv
// host end: safe brake entry sequence
`timescale 1ns/10ps
`include "brake_params.svh"
module bldc_brake_host
	import brake_pkg::*;
(
	input wire logic clk_sys, // 25 MHz clock
	input wire logic reset, // synchronous, active high
	brake_if.host link, // driver pins
	input wire logic brakeReq, // pulse: start braking
	input wire logic [7:0] rampCode, // ramp code for braking
	input wire logic [7:0] dutyCode, // duty code for braking
	input wire logic [15:0] clientDelay, // extra settle cycles
	output logic busy_q, // sequence in progress
	output logic braking_q, // braking applied
	output logic fault_q // driver reports fault
);
	host_state_t state_q;
	logic [15:0] cnt_q;
	logic brakeN_q;
	logic en_q;
	logic [7:0] duty_q;
	logic [7:0] ramp_q;
	logic [1:0] fltSync_q;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_q <= H_IDLE;
			cnt_q <= 16'h0000;
			brakeN_q <= 1'b1;
			en_q <= 1'b0;
			duty_q <= 8'h00;
			ramp_q <= 8'h00;
			busy_q <= 1'b0;
			braking_q <= 1'b0;
		end else begin
			case (state_q)
			H_IDLE: begin
				if (brakeReq) begin
					en_q <= 1'b0;
					busy_q <= 1'b1;
					state_q <= H_ZERO;
				end
			end
			H_ZERO: begin
				ramp_q <= 8'h00;
				duty_q <= 8'h00;
				cnt_q <= 16'(`SETTLE_CYCLES) + clientDelay;
				state_q <= H_SETTLE;
			end
			H_SETTLE: begin
				if (cnt_q == 16'h0000) begin
					brakeN_q <= 1'b0;
					state_q <= H_BRAKE;
				end else
					cnt_q <= cnt_q - 16'h0001;
			end
			H_BRAKE: begin
				en_q <= 1'b1;
				ramp_q <= rampCode;
				cnt_q <= 16'(`SETTLE_CYCLES) + clientDelay;
				state_q <= H_RAMP;
			end
			H_RAMP: begin
				if (cnt_q == 16'h0000) begin
					duty_q <= dutyCode;
					braking_q <= 1'b1;
					busy_q <= 1'b0;
					state_q <= H_RUN;
				end else
					cnt_q <= cnt_q - 16'h0001;
			end
			H_RUN: begin
				state_q <= H_RUN;
			end
			default: state_q <= H_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			fltSync_q <= 2'b11;
			fault_q <= 1'b0;
		end else begin
			fltSync_q <= {fltSync_q[0], link.faultOutN};
			fault_q <= !fltSync_q[1];
		end
	end

	assign link.brakeSelectN = brakeN_q;
	assign link.driveEnable = en_q;
	assign link.dutyCommand = duty_q;
	assign link.rampRateCommand = ramp_q;
endmodule

//--- src/brake_if.sv
// pins between host controller and motor driver
`timescale 1ns/10ps
interface brake_if;
	logic brakeSelectN;
	logic driveEnable;
	logic [7:0] dutyCommand;
	logic [7:0] rampRateCommand;
	logic faultOutN;
	modport device (input brakeSelectN, driveEnable, dutyCommand,
		rampRateCommand, output faultOutN);
	modport host (output brakeSelectN, driveEnable, dutyCommand,
		rampRateCommand, input faultOutN);
endinterface

//--- src/brake_params.svh
// timing counts, thresholds and reset values for the brake-mode link
`ifndef BRAKE_PARAMS_SVH
`define BRAKE_PARAMS_SVH
`define CLK_MHZ 25
`define ADC_MIN_US 64
`define ADC_CYCLES (`ADC_MIN_US * `CLK_MHZ)
`define SETTLE_US 128
`define SETTLE_CYCLES (`SETTLE_US * `CLK_MHZ)
`define CMD_ZERO_CODE 8'h41
`define DUTY_FULL 8'hff
`define DUTY_ZERO 8'h00
`define RAMP_REF_CODE 8'h69
`define RAMP_REF_S 60
`define DUTY_REF_CODE 8'hcd
`define OV_TRIP_V 10'h195
`define OV_CLEAR_V 10'h18b
`define OT_TRIP_C 8'h55
`define OT_CLEAR_C 8'h4b
`define RAMP_STEP_CYCLES ((`RAMP_REF_S * `CLK_MHZ * 1000000) / 255)
`endif

//--- src/brake_pkg.sv
// types shared by both ends of the brake-mode link
package brake_pkg;
	typedef enum logic [5:0] {
		H_IDLE = 6'b000001,
		H_ZERO = 6'b000010,
		H_SETTLE = 6'b000100,
		H_BRAKE = 6'b001000,
		H_RAMP = 6'b010000,
		H_RUN = 6'b100000
	} host_state_t;
endpackage

//--- testbench/brake_link_props.sv
// wire-level checks on the brake link
`timescale 1ns/10ps
module brake_link_props (
	input wire logic clk_sys, // clock
	input wire logic reset, // sync reset
	input wire logic brakeSelectN, // low brakes
	input wire logic driveEnable, // bridge enable
	input wire logic [7:0] dutyCommand, // duty level
	input wire logic [7:0] rampRateCommand, // ramp level
	input wire logic faultOutN // low on fault
);
	logic [15:0] quiet_q;
	logic [15:0] rampAge_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// saturating, so a long idle never wraps back under the settle time
	always_ff @(posedge clk_sys) begin
		if (reset || driveEnable || dutyCommand != 8'h00
			|| rampRateCommand != 8'h00)
			quiet_q <= 16'h0000;
		else if (quiet_q != 16'hffff)
			quiet_q <= quiet_q + 16'h0001;
	end
	always_ff @(posedge clk_sys) begin
		if (reset || $changed(rampRateCommand))
			rampAge_q <= 16'h0000;
		else if (rampAge_q != 16'hffff)
			rampAge_q <= rampAge_q + 16'h0001;
	end
	rst_idle_a: assert property ($fell(reset) |-> brakeSelectN
		&& !driveEnable && dutyCommand == 8'h00 && faultOutN)
		else $error("link not idle after reset");
	brk_safe_a: assert property ($fell(brakeSelectN) |-> !driveEnable
		&& dutyCommand == 8'h00 && rampRateCommand == 8'h00)
		else $error("brake entered while driving");
	settle_wait_a: assert property ($fell(brakeSelectN)
		|-> quiet_q >= 16'h0c80) else $error("brake before settle time");
	zero_order_a: assert property ($fell(|dutyCommand) |-> !driveEnable)
		else $error("commands zeroed while enabled");
	enable_zero_a: assert property ($rose(driveEnable) && !brakeSelectN
		|-> dutyCommand == 8'h00) else $error("enabled with duty set");
	enable_soon_a: assert property ($fell(brakeSelectN)
		|-> ##[1:20] driveEnable) else $error("no re-enable after brake");
	ramp_first_a: assert property ($changed(dutyCommand) && !brakeSelectN
		|-> rampAge_q >= 16'h0c80) else $error("duty set before ramp settled");
	brake_hold_a: assert property (!brakeSelectN |=> !brakeSelectN)
		else $error("brake select released");
endmodule

//--- testbench/test_bldc_brake_mode_control.sv
// self-checking bench for the brake-mode link
`timescale 1ns/10ps
module test_bldc_brake_mode_control;
	logic clk_sys = 1'b0, reset = 1'b1, jumper = 1'b0, overCurrent = 1'b0;
	logic avgCurrentHigh = 1'b0, brakeReq = 1'b0;
	logic [9:0] busVolts = 10'd310;
	logic [7:0] sinkTempC = 8'd25, rampCode = 8'h00, dutyCode = 8'h00;
	logic [15:0] clientDelay = 16'h0001;
	logic bridgeOn, genMode, faultN, busy, braking, fault;
	logic [7:0] pwmDuty;
	int err_total = 0, checked = 0, seed = 78, i;
	brake_if link();
	bldc_brake_device i_bldc_brake_device (.clk_sys(clk_sys), .reset(reset),
		.link(link.device), .brakeUnlockJumper(jumper), .busVolts(busVolts),
		.sinkTempC(sinkTempC), .overCurrent(overCurrent),
		.avgCurrentHigh(avgCurrentHigh), .bridgeOn_q(bridgeOn),
		.generatorMode_q(genMode), .pwmDuty_q(pwmDuty), .faultOutN_q(faultN));
	bldc_brake_host i_bldc_brake_host (.clk_sys(clk_sys), .reset(reset),
		.link(link.host), .brakeReq(brakeReq), .rampCode(rampCode),
		.dutyCode(dutyCode), .clientDelay(clientDelay), .busy_q(busy),
		.braking_q(braking), .fault_q(fault));
	brake_link_props props (.clk_sys(clk_sys), .reset(reset),
		.brakeSelectN(link.brakeSelectN), .driveEnable(link.driveEnable),
		.dutyCommand(link.dutyCommand), .rampRateCommand(link.rampRateCommand),
		.faultOutN(link.faultOutN));
	always #20 clk_sys = ~clk_sys;
	function automatic logic [7:0] expDuty(input logic [7:0] c);
		return (c < 8'h41) ? 8'h00 : c;
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// full entry sequence; a ramp code under 65 reads as zero and keeps the duty sweep short
	task automatic runSeq(input logic jmp, input logic [7:0] d);
		int k;
		reset = 1'b1;
		jumper = jmp;
		dutyCode = d;
		// ramp codes under the threshold must read as zero, else the sweep outlasts the wait
		rampCode = 8'($unsigned($random(seed)) % 65);
		clientDelay = 16'h0001 + 16'($unsigned($random(seed)) % 16);
		repeat (3) @(negedge clk_sys);
		reset = 1'b0;
		check({bridgeOn, genMode, faultN}, 8'h01);
		check(pwmDuty, 8'h00);
		brakeReq = 1'b1;
		@(negedge clk_sys);
		brakeReq = 1'b0;
		for (k = 0; k < 20000 && busy !== 1'b0; k++)
			@(negedge clk_sys);
		check(braking, 1'b1);
		repeat (8) @(negedge clk_sys);
		check(genMode, jmp);
		check(bridgeOn, 1'b1);
		for (k = 0; k < 5000 && pwmDuty !== expDuty(d); k++)
			@(negedge clk_sys);
		check(pwmDuty, expDuty(d));
	endtask
	initial begin
		repeat (60000) @(posedge clk_sys);
		err_total++;
		results();
	end
	initial begin
		runSeq(1'b1, 8'h41 + 8'($unsigned($random(seed)) % 190));
		overCurrent = 1'b1;
		avgCurrentHigh = 1'b1;
		repeat (20) @(negedge clk_sys);
		check({bridgeOn, faultN}, 8'h03);
		check(pwmDuty, dutyCode);
		overCurrent = 1'b0;
		avgCurrentHigh = 1'b0;
		// hysteresis: the middle value must keep the fault from before
		for (i = 0; i < 3; i++) begin
			busVolts = (i == 0) ? 10'd406 : (i == 1) ? 10'd396 : 10'd394;
			repeat (10) @(negedge clk_sys);
			check({faultN, bridgeOn, fault}, (i == 2) ? 8'h06 : 8'h01);
		end
		for (i = 0; i < 3; i++) begin
			sinkTempC = (i == 0) ? 8'd86 : (i == 1) ? 8'd80 : 8'd74;
			repeat (10) @(negedge clk_sys);
			check({faultN, bridgeOn}, (i == 2) ? 8'h03 : 8'h00);
		end
		check(pwmDuty, dutyCode);
		runSeq(1'b0, 8'($unsigned($random(seed)) % 65));
		// motor mode: over-current cuts the bridge and pulls the fault low
		overCurrent = 1'b1;
		repeat (10) @(negedge clk_sys);
		check({bridgeOn, faultN}, 8'h00);
		overCurrent = 1'b0;
		repeat (10) @(negedge clk_sys);
		check({bridgeOn, faultN}, 8'h03);
		results();
	end
endmodule
